// ==== core/bsr_pkg.sv ====
package bsr_pkg;

    localparam int          IR_W         = 10;
    localparam int          DATA_W       = 32;
    localparam int          ADDR_W       = 4;
    localparam int          MAX_CHAIN    = 1632;
    localparam int          MIN_CHAIN    = 603;

    // instruction codes
    localparam logic [9:0]  IR_SAMPLE    = 10'h005;
    localparam logic [9:0]  IR_EXTEST    = 10'h00F;
    localparam logic [9:0]  IR_HIGHZ     = 10'h00B;
    localparam logic [9:0]  IR_CLAMP     = 10'h00A;
    localparam logic [9:0]  IR_IDCODE    = 10'h006;
    localparam logic [9:0]  IR_BYPASS    = 10'h3FF;
    localparam logic [9:0]  IR_CAPTURE   = 10'h001;

    // position of each bit inside a 3-bit cell
    localparam int          CELL_W       = 3;
    localparam int          BIT_OUT      = 0;
    localparam int          BIT_OE       = 1;
    localparam int          BIT_IN       = 2;

    // register map, byte addresses
    localparam logic [3:0]  REG_CTRL     = 4'h0;
    localparam logic [3:0]  REG_STATUS   = 4'h4;
    localparam logic [3:0]  REG_LENGTH   = 4'h8;
    localparam int          CTRL_EN_BIT  = 0;
    localparam logic        CTRL_EN_RST  = 1'b1;
    localparam int          STAT_ST_LSB  = 16;

    typedef enum logic [15:0] {
        ST_RESET  = 16'h0001,
        ST_IDLE   = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SHF_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PAU_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SHF_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PAU_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } bsr_tap_t;

endpackage

// ==== core/bsr_chain.sv ====
// Overview of operation
// [RULE_01] chain runs from the data-in pin through every cell to the data-out pin
// [RULE_02] every pin cell holds output, output-enable and input bits
// [RULE_03] capture takes core output, core enable and pad input
// [RULE_04] update stage drives pad value and enable when boundary mode is selected
// [RULE_05] shift, capture and update strobes all come from the tap state machine
// [RULE_06] boundary or core selection at pins is decoded from the instruction
// [RULE_07] high-impedance instruction turns off every pad enable
// [RULE_08] each cell's serial out feeds the next cell's serial in
// [RULE_09] general pin cell input update bit drives the core input
// [RULE_10] clock-input cell captures 0, 1, pad; pad goes to the clock net
// [RULE_11] configuration-input cell captures 0, 1, pad; pad goes to control logic
// [RULE_12] open-drain cell captures 0, core enable, pad; pad feeds configuration control
// [RULE_13] dedicated output cell captures core value, 0, 0; no update use
// [RULE_14] test port pins and supplies have no cell in the chain
// [RULE_15] chain length is a parameter of at most 1632 bits
// [RULE_16] code 005 samples pins while the core keeps control
// [RULE_17] a preloaded pattern waits in the update stage for an external test
// [RULE_18] code 00F forces update values on pins and captures pin inputs
// [RULE_19] code 00B selects bypass and floats all pins; the dedicated output pin has no enable and keeps driving the core value
// [RULE_20] test-logic-reset disables boundary logic and loads the identification code
// [RULE_21] keepers and pull-ups stay on under float, clamp and external test
// [RULE_22] capture and shift on rising test clock, update on falling edge
// [RULE_23] tester shifts exactly the chain length before each update
module bsr_chain
    import bsr_pkg::*;
#(
    parameter int N_GPIO  = 190,
    parameter int N_CLKIN = 4,
    parameter int N_CFGIN = 4,
    parameter int N_OD    = 2,
    parameter int N_OUT   = 1
)(
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [DATA_W-1:0]   avs_writedata,
    output logic      [DATA_W-1:0]   avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic                tck,
    input  wire logic                tms,
    input  wire logic                tdi,
    output logic                     tdo,
    output logic                     tdo_oe,
    input  wire logic [N_GPIO-1:0]   core_output_value,
    input  wire logic [N_GPIO-1:0]   core_output_enable,
    output logic      [N_GPIO-1:0]   core_input_drive,
    input  wire logic [N_GPIO-1:0]   pad_in,
    output logic      [N_GPIO-1:0]   pad_out,
    output logic      [N_GPIO-1:0]   pad_oe,
    output logic                     pad_keeper_en,
    input  wire logic [N_CLKIN-1:0]  clk_pad_in,
    output logic      [N_CLKIN-1:0]  clk_net_out,
    input  wire logic [N_CFGIN-1:0]  cfg_pad_in,
    output logic      [N_CFGIN-1:0]  cfg_ctrl_out,
    input  wire logic [N_OD-1:0]     od_core_oe,
    input  wire logic [N_OD-1:0]     od_pad_in,
    output logic      [N_OD-1:0]     od_pad_oe,
    output logic      [N_OD-1:0]     od_cfg_out,
    input  wire logic [N_OUT-1:0]    out_core_value,
    output logic      [N_OUT-1:0]    out_pad_out
);

    localparam int N_CELLS = N_GPIO + N_CLKIN + N_CFGIN + N_OD + N_OUT;
    localparam int LEN     = CELL_W * N_CELLS; // see [RULE_02]
    localparam int PIN_W   = N_GPIO + N_CLKIN + N_CFGIN + N_OD;
    localparam int B_CLK   = N_GPIO;
    localparam int B_CFG   = B_CLK + N_CLKIN;
    localparam int B_OD    = B_CFG + N_CFGIN;
    localparam int B_OUT   = B_OD + N_OD;

    // refused at elaboration: a group without cells or a chain beyond the family's longest
    if (N_GPIO < 1 || N_CLKIN < 1 || N_CFGIN < 1 || N_OD < 1 || N_OUT < 1) begin : g_bad_groups
        $error("every pin group needs at least one cell");
    end
    if (LEN > MAX_CHAIN) begin : g_bad_length // see [RULE_15]
        $error("chain longer than the largest family member");
    end

    function automatic logic is_boundary(input logic [IR_W-1:0] code);
        return (code == IR_SAMPLE) || (code == IR_EXTEST);
    endfunction

    // two-flop synchronisers for test pins and pads; tck gets a third stage for edges
    logic [PIN_W+2:0] sync_m;
    logic [PIN_W+2:0] sync_s;
    logic             tck_d;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync_m <= '0;
            sync_s <= '0;
            tck_d  <= 1'b0;
        end else begin
            sync_m <= {od_pad_in, cfg_pad_in, clk_pad_in, pad_in, tdi, tms, tck};
            sync_s <= sync_m;
            tck_d  <= sync_s[0];
        end
    end

    wire              tck_s    = sync_s[0];
    wire              tms_s    = sync_s[1];
    wire              tdi_s    = sync_s[2];
    wire [N_GPIO-1:0] gpio_s   = sync_s[3 +: N_GPIO];
    wire [N_CLKIN-1:0] clk_s   = sync_s[3+B_CLK +: N_CLKIN];
    wire [N_CFGIN-1:0] cfg_s   = sync_s[3+B_CFG +: N_CFGIN];
    wire [N_OD-1:0]   od_s     = sync_s[3+B_OD +: N_OD];
    wire              tck_rise = tck_s & ~tck_d;
    wire              tck_fall = ~tck_s & tck_d;

    // bus-side control and status
    logic             bst_enable;
    bsr_tap_t         tap;
    bsr_tap_t         next_tap;
    logic [IR_W-1:0]  ir;
    logic [IR_W-1:0]  ir_sh;
    logic [LEN-1:0]   cap;
    logic [LEN-1:0]   upd;
    logic             byp;

    wire bus_req  = (avs_read | avs_write) & avs_waitrequest;
    wire bus_wr   = avs_write & ~avs_waitrequest;
    wire hit_ctrl = (avs_address == REG_CTRL);
    wire hit_stat = (avs_address == REG_STATUS);
    wire hit_len  = (avs_address == REG_LENGTH);
    wire [DATA_W-1:0] next_rdata =
        hit_ctrl ? DATA_W'(bst_enable) :
        hit_stat ? {16'(tap), 6'h00, ir} :
        hit_len  ? DATA_W'(LEN) : '0;

    // one wait state per access: the answer stands in the cycle waitrequest drops
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else begin
            avs_waitrequest <= ~bus_req;
            if (bus_req)
                avs_readdata <= next_rdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            bst_enable <= CTRL_EN_RST;
        else if (bus_wr && hit_ctrl)
            bst_enable <= avs_writedata[CTRL_EN_BIT];
    end

    // tap state machine: the only source of capture, shift and update strobes
    always_comb begin
        case (tap)
            ST_RESET:  next_tap = tms_s ? ST_RESET  : ST_IDLE;
            ST_IDLE:   next_tap = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_tap = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_tap = tms_s ? ST_EX1_DR : ST_SHF_DR;
            ST_SHF_DR: next_tap = tms_s ? ST_EX1_DR : ST_SHF_DR;
            ST_EX1_DR: next_tap = tms_s ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: next_tap = tms_s ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: next_tap = tms_s ? ST_UPD_DR : ST_SHF_DR;
            ST_UPD_DR: next_tap = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_tap = tms_s ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: next_tap = tms_s ? ST_EX1_IR : ST_SHF_IR;
            ST_SHF_IR: next_tap = tms_s ? ST_EX1_IR : ST_SHF_IR;
            ST_EX1_IR: next_tap = tms_s ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: next_tap = tms_s ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: next_tap = tms_s ? ST_UPD_IR : ST_SHF_IR;
            ST_UPD_IR: next_tap = tms_s ? ST_SEL_DR : ST_IDLE;
            default:   next_tap = ST_RESET;
        endcase
    end

    // clearing the enable bit parks the port in test-logic-reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            tap <= ST_RESET;
        else if (!bst_enable)
            tap <= ST_RESET;
        else if (tck_rise)
            tap <= next_tap; // see [RULE_05]
    end

    // instruction register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ir    <= IR_IDCODE;
            ir_sh <= '0;
        end else if (tap == ST_RESET) begin
            ir    <= IR_IDCODE; // see [RULE_20]
        end else if (tck_rise && tap == ST_CAP_IR) begin
            ir_sh <= IR_CAPTURE;
        end else if (tck_rise && tap == ST_SHF_IR) begin
            ir_sh <= {tdi_s, ir_sh[IR_W-1:1]};
        end else if (tck_fall && tap == ST_UPD_IR) begin
            ir    <= ir_sh;
        end
    end

    wire bsr_sel   = is_boundary(ir);              // see [RULE_06]
    wire mode_ext  = (ir == IR_EXTEST) || (ir == IR_CLAMP); // see [RULE_06]
    wire mode_test = (ir == IR_EXTEST);
    wire highz     = (ir == IR_HIGHZ);             // see [RULE_07] [RULE_19]

    // capture values per pin type; supplies and test pins have no cell
    logic [LEN-1:0] cap_in; // see [RULE_14]
    genvar g;
    generate
        for (g = 0; g < N_GPIO; g++) begin : g_gpio
            assign cap_in[CELL_W*g+BIT_OUT] = core_output_value[g];  // see [RULE_03]
            assign cap_in[CELL_W*g+BIT_OE]  = core_output_enable[g]; // see [RULE_03]
            assign cap_in[CELL_W*g+BIT_IN]  = gpio_s[g];             // see [RULE_03]
        end
        for (g = 0; g < N_CLKIN; g++) begin : g_clk
            assign cap_in[CELL_W*(B_CLK+g) +: CELL_W] = {clk_s[g], 1'b1, 1'b0}; // see [RULE_10]
        end
        for (g = 0; g < N_CFGIN; g++) begin : g_cfg
            assign cap_in[CELL_W*(B_CFG+g) +: CELL_W] = {cfg_s[g], 1'b1, 1'b0}; // see [RULE_11]
        end
        for (g = 0; g < N_OD; g++) begin : g_od
            assign cap_in[CELL_W*(B_OD+g) +: CELL_W] = {od_s[g], od_core_oe[g], 1'b0}; // see [RULE_12]
        end
        for (g = 0; g < N_OUT; g++) begin : g_out
            assign cap_in[CELL_W*(B_OUT+g) +: CELL_W] = {1'b0, 1'b0, out_core_value[g]}; // see [RULE_13]
        end
    endgenerate

    // capture and shift stage; tdi enters the top bit and bit 0 leaves toward tdo
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cap <= '0;
            byp <= 1'b0;
        end else if (tck_rise && tap == ST_CAP_DR) begin
            if (bsr_sel)
                cap <= cap_in;                 // see [RULE_22]
            byp <= 1'b0;
        end else if (tck_rise && tap == ST_SHF_DR) begin
            if (bsr_sel)
                cap <= {tdi_s, cap[LEN-1:1]};  // see [RULE_01] [RULE_08] [RULE_22]
            byp <= tdi_s;
        end
    end

    // update stage loads on the falling edge; a preload under sample waits here
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            upd <= '0;
        else if (tck_fall && tap == ST_UPD_DR && bsr_sel)
            upd <= cap; // see [RULE_17] [RULE_22]
    end

    // tdo changes on the falling edge and floats outside the shift states
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= (tap == ST_SHF_DR) || (tap == ST_SHF_IR);
            if (tap == ST_SHF_IR)
                tdo <= ir_sh[0];
            else if (tap == ST_SHF_DR)
                tdo <= bsr_sel ? cap[0] : byp; // see [RULE_01] [RULE_19]
        end
    end

    // pin drive; only general cells use their update bits, dedicated cells leave them open
    logic [N_GPIO-1:0] next_pad_out;
    logic [N_GPIO-1:0] next_pad_oe;
    logic [N_GPIO-1:0] next_core_in;
    generate
        for (g = 0; g < N_GPIO; g++) begin : g_drive
            assign next_pad_out[g] = mode_ext ? upd[CELL_W*g+BIT_OUT] : core_output_value[g]; // see [RULE_04] [RULE_18]
            assign next_pad_oe[g]  = highz ? 1'b0 :
                                     mode_ext ? upd[CELL_W*g+BIT_OE] : core_output_enable[g]; // see [RULE_04] [RULE_07]
            assign next_core_in[g] = mode_test ? upd[CELL_W*g+BIT_IN] : gpio_s[g]; // see [RULE_09]
        end
    endgenerate

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pad_out          <= '0;
            pad_oe           <= '0;
            core_input_drive <= '0;
            pad_keeper_en    <= 1'b0;
            clk_net_out      <= '0;
            cfg_ctrl_out     <= '0;
            od_pad_oe        <= '0;
            od_cfg_out       <= '0;
            out_pad_out      <= '0;
        end else begin
            pad_out          <= next_pad_out;
            pad_oe           <= next_pad_oe;
            core_input_drive <= next_core_in;
            pad_keeper_en    <= highz | mode_ext; // see [RULE_21]
            clk_net_out      <= clk_s;            // see [RULE_10]
            cfg_ctrl_out     <= cfg_s;            // see [RULE_11]
            od_pad_oe        <= highz ? '0 : od_core_oe;
            od_cfg_out       <= od_s;             // see [RULE_12]
            out_pad_out      <= out_core_value;   // see [RULE_13]
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_upd_fall;
        tck_fall && tap == ST_UPD_DR && bsr_sel;
    endsequence

    sequence s_shift_rise;
        tck_rise && tap == ST_SHF_DR && bsr_sel;
    endsequence

    a_reset_loads_id: assert property (tap == ST_RESET |=> ir == IR_IDCODE) // see [RULE_20]
        else $error("instruction not identification after test-logic-reset");

    a_shift_moves: assert property (s_shift_rise |=>
        cap[LEN-1] == $past(tdi_s) && cap[0] == $past(cap[1])) // see [RULE_08]
        else $error("chain did not shift by one bit");

    a_tdo_from_chain: assert property (tck_fall && tap == ST_SHF_DR && bsr_sel |=>
        tdo == $past(cap[0]) && tdo_oe) // see [RULE_01]
        else $error("tdo not the last chain bit");

    a_capture_gpio: assert property (tck_rise && tap == ST_CAP_DR && bsr_sel |=>
        cap[BIT_OUT] == $past(core_output_value[0]) &&
        cap[BIT_OE] == $past(core_output_enable[0]) && cap[BIT_IN] == $past(gpio_s[0])) // see [RULE_03]
        else $error("general cell capture wrong");

    a_capture_fixed: assert property (tck_rise && tap == ST_CAP_DR && bsr_sel |=>
        cap[CELL_W*B_CLK +: 2] == 2'b10 && cap[CELL_W*B_OUT+BIT_OE +: 2] == 2'b00) // see [RULE_10]
        else $error("dedicated cell constants wrong");

    a_update_on_fall: assert property (s_upd_fall |=> upd == $past(cap)) // see [RULE_22]
        else $error("update stage missed the falling edge");

    a_extest_drives: assert property (mode_test ##1 mode_test |=>
        pad_out[0] == $past(upd[BIT_OUT]) && core_input_drive[0] == $past(upd[BIT_IN])) // see [RULE_18]
        else $error("external test not driving pins from update stage");

    a_sample_normal: assert property (ir == IR_SAMPLE |=>
        pad_out == $past(core_output_value) && pad_oe == $past(core_output_enable)) // see [RULE_16]
        else $error("sample disturbed the pins");

    a_highz_float: assert property (highz |=> pad_oe == '0 && od_pad_oe == '0 && pad_keeper_en) // see [RULE_07]
        else $error("pins driven under high-impedance");

endmodule // bsr_chain

// ==== sim/bsr_tester.sv ====
// tester on the far side of the test port; tck stands low between frames
module bsr_tester (
    input  wire logic clock,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ps;

    // tms and tdi rest at their pull-up level, tck at its pull-down level
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // one 160 ns tck period; tdo is taken just before the rise that shifts it
    task automatic step(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        repeat (8) @(posedge clock);
        q = tdo;
        tck <= 1'b1;
        repeat (8) @(posedge clock);
        tck <= 1'b0;
    endtask

    task automatic walk(input logic [7:0] seq, input int n);
        logic q;
        for (int i = 0; i < n; i++) begin
            step(seq[i], 1'b1, q);
        end
        tdi <= 1'b1;
    endtask

    // exactly n bits, tms high on the last, then update and back to idle
    task automatic scan(input logic [31:0] din, input int n, output logic [31:0] dout);
        logic q;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        walk(8'h01, 2);
    endtask

    task automatic tlr();
        walk(8'h1f, 6);
    endtask

    task automatic ir(input logic [9:0] code);
        logic [31:0] x;
        walk(8'h03, 4);
        scan({22'h0, code}, 10, x);
    endtask

    // a preload pattern is shifted in the same way under sample
    task automatic dr(input logic [31:0] din, input int n, output logic [31:0] dout);
        walk(8'h01, 3);
        scan(din, n, dout);
    endtask
endmodule // bsr_tester

// ==== sim/boundary_scan_cell_chain_tb_top.sv ====
module boundary_scan_cell_chain_tb_top
    import bsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock, rst, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, d, q, pre;
    logic        tck, tms, tdi, tdo, tdo_oe, pad_keeper_en;
    logic [1:0]  core_output_value, core_output_enable, core_input_drive;
    logic [1:0]  pad_in, pad_out, pad_oe;
    logic        clk_pad_in, clk_net_out, cfg_pad_in, cfg_ctrl_out;
    logic        od_core_oe, od_pad_in, od_pad_oe, od_cfg_out;
    logic        out_core_value, out_pad_out;
    int          failures, checks_done;
    bit          bq[$];

    bsr_chain #(.N_GPIO(2), .N_CLKIN(1), .N_CFGIN(1), .N_OD(1), .N_OUT(1)) i_dut (
        .clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .tck, .tms, .tdi, .tdo, .tdo_oe,
        .core_output_value, .core_output_enable, .core_input_drive, .pad_in,
        .pad_out, .pad_oe, .pad_keeper_en, .clk_pad_in, .clk_net_out, .cfg_pad_in,
        .cfg_ctrl_out, .od_core_oe, .od_pad_in, .od_pad_oe, .od_cfg_out,
        .out_core_value, .out_pad_out);

    bsr_tester i_tst (.clock, .tck, .tms, .tdi, .tdo);

    always #5 clock = ~clock;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !w;
        avs_write <= w;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rnd();
        logic [31:0] r;
        r = $urandom;
        core_output_value <= r[1:0];
        core_output_enable <= r[3:2];
        pad_in <= r[5:4];
        {clk_pad_in, cfg_pad_in, od_core_oe, od_pad_in, out_core_value} <= r[10:6];
    endtask

    // capture image: gpio cells, clock in, config in, open drain, dedicated out
    function automatic logic [17:0] cap();
        logic [17:0] v;
        for (int c = 0; c < 2; c++) begin
            v[3*c+:3] = {pad_in[c], core_output_enable[c], core_output_value[c]};
        end
        v[6+:3]  = {clk_pad_in, 1'b1, 1'b0};
        v[9+:3]  = {cfg_pad_in, 1'b1, 1'b0};
        v[12+:3] = {od_pad_in, od_core_oe, 1'b0};
        v[15+:3] = {2'b00, out_core_value};
        return v;
    endfunction

    task automatic thru();
        chk({clk_net_out, cfg_ctrl_out, od_cfg_out, out_pad_out},
            {clk_pad_in, cfg_pad_in, od_pad_in, out_core_value});
    endtask

    initial begin
        #500_000;
        failures++;
        stop_test();
    end

    initial begin
        clock = 0; rst = 1; avs_read = 0; avs_write = 0; avs_address = '0;
        avs_writedata = '0; core_output_value = '0; core_output_enable = '0;
        pad_in = '0; clk_pad_in = 0; cfg_pad_in = 0; od_core_oe = 0;
        od_pad_in = 0; out_core_value = 0;
        void'($urandom(32'hf1a9_654c));
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
        bus(0, REG_STATUS, 0, d);
        chk(d, {ST_RESET, 6'h00, IR_IDCODE});
        bus(0, REG_LENGTH, 0, d);
        chk(d, 32'h0000_0012);
        bus(1, REG_LENGTH, 32'h0000_0000, d);
        bus(0, REG_LENGTH, 0, d);
        chk(d, 32'h0000_0012);
        bus(0, 4'hc, 0, d);
        chk(d, 32'h0000_0000);
        bus(0, REG_CTRL, 0, d);
        chk(d[0], CTRL_EN_RST);
        i_tst.tlr();
        i_tst.ir(IR_SAMPLE);
        bus(0, REG_STATUS, 0, d);
        chk(d[9:0], IR_SAMPLE);
        for (int k = 0; k < 3; k++) begin
            rnd();
            pre = $urandom;
            i_tst.dr(pre, 18, q);
            chk(q[17:0], cap());
            chk({pad_out, pad_oe}, {core_output_value, core_output_enable});
            chk(core_input_drive, pad_in);
            chk(pad_keeper_en, 1'b0);
            chk(tdo_oe, 1'b0);
            thru();
        end
        i_tst.ir(IR_EXTEST);
        for (int k = 0; k < 2; k++) begin
            repeat (4) @(posedge clock);
            chk({pad_out, pad_oe}, {pre[3], pre[0], pre[4], pre[1]});
            chk(core_input_drive, {pre[5], pre[2]});
            chk({pad_keeper_en, od_pad_oe}, {1'b1, od_core_oe});
            rnd();
            pre = $urandom;
            i_tst.dr(pre, 18, q);
            chk(q[17:0], cap());
            thru();
        end
        i_tst.ir(IR_CLAMP);
        repeat (4) @(posedge clock);
        chk({pad_out, pad_oe}, {pre[3], pre[0], pre[4], pre[1]});
        chk(core_input_drive, pad_in);
        chk({pad_keeper_en, od_pad_oe}, {1'b1, od_core_oe});
        i_tst.ir(IR_HIGHZ);
        repeat (4) @(posedge clock);
        chk({pad_oe, od_pad_oe, pad_keeper_en}, 4'b0001);
        pre = $urandom;
        bq = {1'b0};
        i_tst.dr(pre, 8, q);
        for (int i = 0; i < 8; i++) begin
            bq.push_back(pre[i]);
            chk(q[i], bq.pop_front());
        end
        bus(1, REG_CTRL, 32'h0000_0000, d);
        // the instruction reloads one cycle after the port parks in reset
        repeat (2) @(posedge clock);
        bus(0, REG_STATUS, 0, d);
        chk(d, {ST_RESET, 6'h00, IR_IDCODE});
        repeat (4) @(posedge clock);
        chk({pad_out, pad_oe, pad_keeper_en},
            {core_output_value, core_output_enable, 1'b0});
        bus(1, REG_CTRL, 32'h0000_0001, d);
        stop_test();
    end
endmodule // boundary_scan_cell_chain_tb_top
